//--- verilog/led_fault_pkg.sv
// shared constants, carrier types and state layout of the led fault supervisor
// What this block does
// - overvoltage locks out strings below regulation
// - enable low clears all string lockouts
// - output short drives fault flag low
// - string above short threshold loses its sink
// - input above lockout threshold enables device
// - input low over 2 us disables device
// - enable low stops boost and sinks immediately
// - primary trip blanks boost until next switching cycle starts
// - secondary trip latches, stops all, flags fault
// - string ground short holds startup, flags fault
// - soft start proceeds once ground short clears
// - open string raises output until overvoltage
// - after lockout output target returns to normal
// - shorted string stays off until enable toggles
// - input lockout clears every latched fault
// - overvoltage stops switching, resumes when lower
// - output short turns boost and sinks off
// - dimming low turns boost and sinks off
package led_fault_pkg;

	// ==========================================================
	// timing
	localparam int CLK_MHZ      = 100;
	localparam int INPUT_LOCKOUT_HOLD_NS = 2000;
	// least time, so rounded up
	localparam int INPUT_LOCKOUT_CYC     = (INPUT_LOCKOUT_HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W        = 8;
	localparam int NUM_STRINGS  = 4;

	// ==========================================================
	// register map
	localparam logic [7:0] CTRL_OFS           = 8'h00;
	localparam logic [7:0] STATUS_OFS         = 8'h04;
	localparam int         CTRL_OPEN_DET_BIT  = 0;
	localparam logic       CTRL_OPEN_DET_RST  = 1'b1;
	localparam int         STAT_MODE_LSB      = 0;
	localparam int         STAT_SEC_BIT       = 2;
	localparam int         STAT_VIN_BIT       = 3;
	localparam int         STAT_FAULT_BIT     = 4;
	localparam int         STAT_BOOST_BIT     = 5;
	localparam int         STAT_RAISE_BIT     = 6;
	localparam int         STAT_OPEN_LSB      = 8;
	localparam int         STAT_SHORT_LSB     = 12;
	localparam int         STAT_SINK_LSB      = 16;
	localparam logic [1:0] RESP_OKAY          = 2'h0;
	localparam logic [1:0] RESP_SLVERR        = 2'h2;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		ST_OFF   = 2'h0,
		ST_START = 2'h1,
		ST_RUN   = 2'h3
	} mode_type;

	typedef struct packed {
		logic                   over_voltage_sense;
		logic                   output_short_sense;
		logic                   primary_trip;
		logic                   secondary_trip;
		logic [NUM_STRINGS-1:0] string_short;
		logic [NUM_STRINGS-1:0] string_gnd_short;
		logic [NUM_STRINGS-1:0] string_below_reg;
		logic                   input_ok;
		logic                   enable;
		logic                   dim;
		logic                   cycle_tick;
	} sense_type;

	typedef struct packed {
		logic                   boost_en;
		logic [NUM_STRINGS-1:0] sink_en;
		logic                   fault_n;
		logic                   soft_start_go;
		logic                   raise_target;
	} drive_type;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axi_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_type;

	typedef struct packed {
		sense_type              s1;
		sense_type              s2;
		logic                   cyc_d;
		logic [CNT_W-1:0]       lo_cnt;
		logic                   vin_on;
		mode_type               mode;
		logic [NUM_STRINGS-1:0] open_lock;
		logic [NUM_STRINGS-1:0] short_lock;
		logic                   sec_lat;
		logic                   pbp_blk;
		logic                   open_det_en;
		drive_type              drv;
		axi_rsp_type            axi;
		logic                   aw_held;
		logic                   w_held;
		logic [7:0]             awaddr_h;
		logic [31:0]            wdata_h;
		logic [3:0]             wstrb_h;
	} state_type;

endpackage : led_fault_pkg

//--- verilog/led_fault_supervisor.sv
// fault supervisor for a four string boost led driver, with axi4-lite registers
`timescale 1ns/1ns
module led_fault_supervisor (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst_n,
	// comparator and pin indications, asynchronous
	input  wire led_fault_pkg::sense_type  sense_in,
	// power stage controls
	output      led_fault_pkg::drive_type  drive_out,
	// register bus
	input  wire led_fault_pkg::axi_req_type axi_req,
	output      led_fault_pkg::axi_rsp_type axi_rsp
);
	import led_fault_pkg::*;

	// ==========================================================
	// elaboration checks
	localparam logic [CNT_W-1:0] INPUT_LOCKOUT_LIMIT = CNT_W'(INPUT_LOCKOUT_CYC);

	if (INPUT_LOCKOUT_CYC < 1 || INPUT_LOCKOUT_CYC >= (1 << CNT_W)) begin : g_cnt_chk
		$error("lockout filter count does not fit its counter");
	end

	// ==========================================================
	// register helpers
	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = (addr[7:2] == CTRL_OFS[7:2]) || (addr[7:2] == STATUS_OFS[7:2]);
	endfunction : is_mapped

	function automatic logic [31:0] read_word(input logic [7:0] addr, input state_type s);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (addr[7:2] == CTRL_OFS[7:2]) begin
			w[CTRL_OPEN_DET_BIT] = s.open_det_en;
		end else if (addr[7:2] == STATUS_OFS[7:2]) begin
			w[STAT_MODE_LSB +: 2]                = s.mode;
			w[STAT_SEC_BIT]                      = s.sec_lat;
			w[STAT_VIN_BIT]                      = s.vin_on;
			w[STAT_FAULT_BIT]                    = ~s.drv.fault_n;
			w[STAT_BOOST_BIT]                    = s.drv.boost_en;
			w[STAT_RAISE_BIT]                    = s.drv.raise_target;
			w[STAT_OPEN_LSB +: NUM_STRINGS]      = s.open_lock;
			w[STAT_SHORT_LSB +: NUM_STRINGS]     = s.short_lock;
			w[STAT_SINK_LSB +: NUM_STRINGS]      = s.drv.sink_en;
		end
		read_word = w;
	endfunction : read_word

	// ==========================================================
	// state
	state_type st_r;
	state_type st_nxt;
	logic      input_lockout_trip;
	logic      go;
	logic      act;
	logic      off_now;
	logic      clr_locks;
	logic      cyc_rise;

	always_comb begin
		st_nxt    = st_r;
		input_lockout_trip = 1'b0;

		// first stage feeds only the second
		st_nxt.s1    = sense_in;
		st_nxt.s2    = st_r.s1;
		st_nxt.cyc_d = st_r.s2.cycle_tick;
		cyc_rise     = st_r.s2.cycle_tick & ~st_r.cyc_d;

		// input lockout with glitch filter
		if (st_r.s2.input_ok) begin
			st_nxt.lo_cnt = '0;
			st_nxt.vin_on = 1'b1;
		end else if (st_r.lo_cnt == INPUT_LOCKOUT_LIMIT) begin
			input_lockout_trip     = st_r.vin_on;
			st_nxt.vin_on = 1'b0;
		end else begin
			st_nxt.lo_cnt = st_r.lo_cnt + 1'b1;
		end

		// latched faults; a new event wins over the clear
		clr_locks = ~st_r.s2.enable | input_lockout_trip;
		st_nxt.sec_lat = (st_r.sec_lat & ~clr_locks)
			| st_r.s2.secondary_trip;

		off_now = ~st_r.s2.enable | ~st_r.vin_on | st_r.sec_lat
			| st_r.s2.secondary_trip;
		act = (st_r.mode == ST_RUN) & ~off_now;

		st_nxt.open_lock = (st_r.open_lock & {NUM_STRINGS{~clr_locks}})
			| ({NUM_STRINGS{act & st_r.s2.over_voltage_sense}}
			& st_r.s2.string_below_reg);
		st_nxt.short_lock = (st_r.short_lock & {NUM_STRINGS{~clr_locks}})
			| ({NUM_STRINGS{act}} & st_r.s2.string_short);

		// blanking lasts until the next switching cycle starts
		st_nxt.pbp_blk = st_r.s2.primary_trip | (st_r.pbp_blk & ~cyc_rise);

		// start-up sequencing
		go = st_r.s2.enable & st_r.vin_on & ~st_r.sec_lat & ~st_r.s2.secondary_trip;
		case (st_r.mode)
			ST_OFF: begin
				if (go) begin
					st_nxt.mode = ST_START;
				end
			end
			ST_START: begin
				if (!go) begin
					st_nxt.mode = ST_OFF;
				end else if (st_r.s2.string_gnd_short == '0) begin
					st_nxt.mode = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!go) begin
					st_nxt.mode = ST_OFF;
				end
			end
			default: begin
				st_nxt.mode = ST_OFF;
			end
		endcase

		// drive outputs
		st_nxt.drv.boost_en = act & st_r.s2.dim
			& ~st_r.s2.over_voltage_sense
			& ~st_r.s2.output_short_sense
			& ~st_r.s2.primary_trip & ~st_r.pbp_blk;
		// sinks ignore primary trips: only the switch is blanked
		st_nxt.drv.sink_en = {NUM_STRINGS{act & st_r.s2.dim & ~st_r.s2.output_short_sense}}
			& ~(st_r.open_lock | st_r.short_lock | st_r.s2.string_short);
		st_nxt.drv.fault_n = ~(st_r.s2.output_short_sense
			| st_r.sec_lat | st_r.s2.secondary_trip
			| ((st_r.mode == ST_START) & (|st_r.s2.string_gnd_short)));
		st_nxt.drv.soft_start_go = act;
		// keep pushing output up only while an unlocked string lags
		st_nxt.drv.raise_target = act & st_r.open_det_en
			& (|(st_r.s2.string_below_reg & ~st_r.open_lock & ~st_r.short_lock));

		// axi4-lite write path
		if (st_r.axi.bvalid && axi_req.bready) begin
			st_nxt.axi.bvalid = 1'b0;
		end
		if (st_r.axi.awready && axi_req.awvalid) begin
			st_nxt.aw_held  = 1'b1;
			st_nxt.awaddr_h = axi_req.awaddr;
		end
		if (st_r.axi.wready && axi_req.wvalid) begin
			st_nxt.w_held  = 1'b1;
			st_nxt.wdata_h = axi_req.wdata;
			st_nxt.wstrb_h = axi_req.wstrb;
		end
		if (st_r.aw_held && st_r.w_held && !st_r.axi.bvalid) begin
			st_nxt.aw_held    = 1'b0;
			st_nxt.w_held     = 1'b0;
			st_nxt.axi.bvalid = 1'b1;
			st_nxt.axi.bresp  = is_mapped(st_r.awaddr_h) ? RESP_OKAY : RESP_SLVERR;
			if (st_r.awaddr_h[7:2] == CTRL_OFS[7:2] && st_r.wstrb_h[0]) begin
				st_nxt.open_det_en = st_r.wdata_h[CTRL_OPEN_DET_BIT];
			end
		end
		st_nxt.axi.awready = ~st_nxt.aw_held & ~st_nxt.axi.bvalid;
		st_nxt.axi.wready  = ~st_nxt.w_held & ~st_nxt.axi.bvalid;

		// axi4-lite read path
		if (st_r.axi.rvalid && axi_req.rready) begin
			st_nxt.axi.rvalid = 1'b0;
		end
		if (st_r.axi.arready && axi_req.arvalid) begin
			st_nxt.axi.rvalid = 1'b1;
			st_nxt.axi.rdata  = read_word(axi_req.araddr, st_r);
			st_nxt.axi.rresp  = is_mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		st_nxt.axi.arready = ~st_nxt.axi.rvalid;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_r                 <= '0;
			st_r.open_det_en     <= CTRL_OPEN_DET_RST;
			st_r.drv.fault_n     <= 1'b1;
			st_r.axi.awready     <= 1'b1;
			st_r.axi.wready      <= 1'b1;
			st_r.axi.arready     <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign drive_out = st_r.drv;
	assign axi_rsp   = st_r.axi;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_ovp_lock_strings: assert property (
		(act && st_r.s2.over_voltage_sense && !clr_locks)
		|=> ((st_r.open_lock & $past(st_r.s2.string_below_reg)) == $past(st_r.s2.string_below_reg))
	) else $error("low string not locked on overvoltage");

	a_en_clears_locks: assert property (
		(!st_r.s2.enable) |=> (st_r.open_lock == '0 && st_r.short_lock == '0)
	) else $error("enable low left a lockout set");

	a_uvp_flag_low: assert property (
		st_r.s2.output_short_sense |=> (!drive_out.fault_n && drive_out.sink_en == '0)
	) else $error("output short did not pull fault flag");

	a_short_sink_off: assert property (
		(st_r.s2.string_short[0] && act) |=> (!drive_out.sink_en[0] && st_r.short_lock[0])
	) else $error("shorted string still sinking");

	a_input_lockout_enable_on: assert property (
		st_r.s2.input_ok |=> st_r.vin_on
	) else $error("input ok did not enable");

	a_input_lockout_glitch_held: assert property (
		(st_r.vin_on && !st_r.s2.input_ok && st_r.lo_cnt < INPUT_LOCKOUT_LIMIT) |=> st_r.vin_on
	) else $error("lockout taken before filter time");

	a_input_lockout_trip_time: assert property (
		(!st_r.s2.input_ok)[*3] ##1 (!st_r.s2.input_ok && st_r.lo_cnt == INPUT_LOCKOUT_LIMIT)
		|=> (!st_r.vin_on ##1 !drive_out.boost_en)
	) else $error("lockout not taken after filter time");

	a_en_shutdown_now: assert property (
		$fell(st_r.s2.enable) |=> (!drive_out.boost_en && drive_out.sink_en == '0)
	) else $error("enable low did not stop the stage");

	a_pbp_blank_cycle: assert property (
		(st_r.s2.primary_trip && !st_r.s2.secondary_trip && !st_r.s2.output_short_sense
			&& !st_r.sec_lat && st_r.mode != ST_START)
		|=> (!drive_out.boost_en && drive_out.fault_n) ##1 !drive_out.boost_en
	) else $error("primary trip handled wrongly");

	a_sec_latch_hold: assert property (
		st_r.s2.secondary_trip |=> (st_r.sec_lat && !drive_out.fault_n && !drive_out.boost_en)
			##1 (st_r.sec_lat || $past(clr_locks))
	) else $error("secondary trip not latched");

	a_gnd_short_hold: assert property (
		(st_r.mode == ST_START && (|st_r.s2.string_gnd_short))
		|=> (st_r.mode != ST_RUN && !drive_out.fault_n && !drive_out.soft_start_go)
	) else $error("start-up ran into ground short");

	a_gnd_clear_start: assert property (
		(st_r.mode == ST_START && go && st_r.s2.string_gnd_short == '0) |=> st_r.mode == ST_RUN
	) else $error("soft start not released");

	a_open_raise_drop: assert property (
		(st_r.s2.string_below_reg == st_r.open_lock) |=> !drive_out.raise_target
	) else $error("target stays raised after lockout");

	a_input_lockout_clears_sec: assert property (
		(input_lockout_trip && !st_r.s2.secondary_trip) |=> !st_r.sec_lat
	) else $error("lockout left secondary latch set");

	a_ovp_stop_boost: assert property (
		st_r.s2.over_voltage_sense |=> !drive_out.boost_en
	) else $error("boost ran during overvoltage");

	a_dim_all_off: assert property (
		!st_r.s2.dim |=> (!drive_out.boost_en && drive_out.sink_en == '0)
	) else $error("dimming low left the stage on");

	a_sync_two_stage: assert property (
		$past(rst_n) |=> ##1 (st_r.s2 == $past(sense_in, 2))
	) else $error("synchroniser depth wrong");

	a_open_raise_on: assert property (
		(act && st_r.open_det_en && st_r.s2.string_below_reg[0] && !st_r.open_lock[0]
			&& !st_r.short_lock[0] && !st_r.s2.output_short_sense)
		|=> (drive_out.raise_target && drive_out.fault_n)
	) else $error("lagging string did not raise the target");

	a_uvp_boost_off: assert property (
		st_r.s2.output_short_sense |=> !drive_out.boost_en
	) else $error("boost ran during output short");

	a_flag_release: assert property (
		(!st_r.s2.output_short_sense && !st_r.s2.secondary_trip && !st_r.sec_lat
			&& st_r.mode != ST_START)
		|=> drive_out.fault_n
	) else $error("fault flag low without a fault");

	a_short_lock_hold: assert property (
		(st_r.short_lock[0] && st_r.s2.enable && !input_lockout_trip) |=> st_r.short_lock[0]
	) else $error("short lockout dropped without enable toggle");

endmodule : led_fault_supervisor

//--- dv/power_stage_model.sv
// power stage oscillator and disconnect switch model facing the supervisor
`timescale 1ns/1ns
module power_stage_model (
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	// supervisor controls
	input  wire led_fault_pkg::drive_type drive,
	// oscillator and supply switch state
	output      logic                     cycle_tick,
	output      logic                     supply_on
);
	import led_fault_pkg::*;
	logic [3:0] div_r;
	// ==========================================================
	// oscillator runs free; the switch follows the flag a cycle late
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			div_r     <= 4'h0;
			supply_on <= 1'b1;
		end else begin
			div_r     <= div_r + 4'h1;
			supply_on <= drive.fault_n;
		end
	end
	assign cycle_tick = div_r[3];
endmodule : power_stage_model

//--- dv/tb_top.sv
// self-checking bench for the led fault supervisor
`timescale 1ns/1ns
module tb_top;
	import led_fault_pkg::*;
	localparam sense_type NOM = '{input_ok: 1'b1, enable: 1'b1, dim: 1'b1, default: '0};
	logic        sys_clk;
	logic        rst_n;
	sense_type   sense_r;
	sense_type   sense_w;
	drive_type   drive_out;
	axi_req_type axi_req;
	axi_rsp_type axi_rsp;
	logic        tick;
	logic        supply_on;
	int          mismatches;
	int          check_count;
	sense_type   s;
	sense_type   row_in[5];
	logic [5:0]  row_exp[5];
	logic [31:0] rd;
	logic [1:0]  rs;

	led_fault_supervisor led_fault_supervisor_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.sense_in(sense_w), .drive_out(drive_out), .axi_req(axi_req), .axi_rsp(axi_rsp));
	power_stage_model power_stage_model_i (.sys_clk(sys_clk), .rst_n(rst_n),
		.drive(drive_out), .cycle_tick(tick), .supply_on(supply_on));

	always_comb begin
		sense_w = sense_r;
		sense_w.cycle_tick = tick;
	end

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========================================================
	// helpers
	task automatic final_report;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			mismatches++;
		end
	endtask : chk

	// packs boost, sinks and flag as one six bit value
	task automatic chk_drv(input logic [5:0] exp);
		chk("drive", {26'h0, exp}, {26'h0, drive_out.boost_en, drive_out.sink_en, drive_out.fault_n});
	endtask : chk_drv

	task automatic set(input sense_type v, input int n);
		@(posedge sys_clk);
		sense_r <= v;
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : set

	task automatic toggle_en;
		sense_type e;
		e = NOM;
		e.enable = 1'b0;
		set(e, 5);
		set(NOM, 40);
	endtask : toggle_en

	// sampled at the falling edge so the rising edge sees settled values
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] resp, output logic [31:0] q);
		logic aw, w, ar, done;
		int   i;
		@(posedge sys_clk);
		axi_req.awvalid <= wr;
		axi_req.wvalid  <= wr;
		axi_req.bready  <= wr;
		axi_req.arvalid <= !wr;
		axi_req.rready  <= !wr;
		axi_req.awaddr  <= a;
		axi_req.araddr  <= a;
		axi_req.wdata   <= d;
		axi_req.wstrb   <= 4'hF;
		done = 1'b0;
		for (i = 0; i < 50 && !done; i++) begin
			@(negedge sys_clk);
			aw   = axi_req.awvalid & axi_rsp.awready;
			w    = axi_req.wvalid & axi_rsp.wready;
			ar   = axi_req.arvalid & axi_rsp.arready;
			done = wr ? axi_rsp.bvalid : axi_rsp.rvalid;
			resp = wr ? axi_rsp.bresp : axi_rsp.rresp;
			q    = axi_rsp.rdata;
			@(posedge sys_clk);
			if (aw) axi_req.awvalid <= 1'b0;
			if (w) axi_req.wvalid <= 1'b0;
			if (ar) axi_req.arvalid <= 1'b0;
			if (done) begin
				axi_req.bready <= 1'b0;
				axi_req.rready <= 1'b0;
			end
		end
		if (!done) begin
			mismatches++;
			final_report();
		end
	endtask : axi

	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		sense_r = NOM;
		axi_req = '0;
		mismatches = 0;
		check_count = 0;
		repeat (10) @(posedge sys_clk);
		#1;
		chk_drv(6'h01);
		chk("soft_start_go", 32'h0, {31'h0, drive_out.soft_start_go});
		@(posedge sys_clk);
		rst_n <= 1'b1;
		set(NOM, 40);
		chk_drv(6'h3F);
		// level conditions, each removed again and expected to restart
		row_in = '{NOM, NOM, NOM, NOM, NOM};
		row_in[1].dim = 1'b0;
		row_in[2].over_voltage_sense = 1'b1;
		row_in[3].output_short_sense = 1'b1;
		row_in[4].primary_trip = 1'b1;
		row_exp = '{6'h3F, 6'h01, 6'h1F, 6'h00, 6'h1F};
		for (int i = 0; i < 5; i++) begin
			set(row_in[i], 5);
			chk_drv(row_exp[i]);
			chk("supply_on", {31'h0, row_exp[i][0]}, {31'h0, supply_on});
			set(NOM, 40);
			chk_drv(6'h3F);
		end
		// open string found at overvoltage, cleared by enable low
		s = NOM;
		s.string_below_reg = 4'h2;
		set(s, 5);
		chk_drv(6'h3F);
		chk("raise_target", 32'h1, {31'h0, drive_out.raise_target});
		s.over_voltage_sense = 1'b1;
		set(s, 5);
		s.over_voltage_sense = 1'b0;
		set(s, 5);
		chk("raise_target", 32'h0, {31'h0, drive_out.raise_target});
		chk_drv(6'h3B);
		set(NOM, 40);
		chk_drv(6'h3B);
		axi(1'b0, STATUS_OFS, 32'h0, rs, rd);
		chk("open_lock", 32'h2, {28'h0, rd[STAT_OPEN_LSB+:4]});
		chk("status_rd_resp", {30'h0, RESP_OKAY}, {30'h0, rs});
		s = NOM;
		s.enable = 1'b0;
		set(s, 3);
		chk_drv(6'h01);
		set(NOM, 40);
		chk_drv(6'h3F);
		// shorted string stays off until enable toggles
		s = NOM;
		s.string_short = 4'h8;
		set(s, 5);
		chk_drv(6'h2F);
		set(NOM, 40);
		chk_drv(6'h2F);
		toggle_en();
		chk_drv(6'h3F);
		// secondary trip: two stage latency, then latched
		s = NOM;
		s.secondary_trip = 1'b1;
		set(s, 2);
		chk_drv(6'h3F);
		@(posedge sys_clk);
		#1;
		chk_drv(6'h00);
		set(NOM, 40);
		chk_drv(6'h00);
		axi(1'b0, STATUS_OFS, 32'h0, rs, rd);
		chk("sec_latch", 32'h1, {31'h0, rd[STAT_SEC_BIT]});
		toggle_en();
		chk_drv(6'h3F);
		// short input dip ignored, long one clears the latch
		set(s, 5);
		set(NOM, 5);
		s = NOM;
		s.input_ok = 1'b0;
		set(s, 150);
		set(NOM, 5);
		axi(1'b0, STATUS_OFS, 32'h0, rs, rd);
		chk("vin_on", 32'h1, {31'h0, rd[STAT_VIN_BIT]});
		chk_drv(6'h00);
		set(s, 250);
		chk_drv(6'h01);
		axi(1'b0, STATUS_OFS, 32'h0, rs, rd);
		chk("vin_on", 32'h0, {31'h0, rd[STAT_VIN_BIT]});
		set(NOM, 40);
		chk_drv(6'h3F);
		// ground short at start holds soft start
		s = NOM;
		s.enable = 1'b0;
		set(s, 5);
		s.enable = 1'b1;
		s.string_gnd_short = 4'h4;
		set(s, 20);
		chk_drv(6'h00);
		chk("soft_start_go", 32'h0, {31'h0, drive_out.soft_start_go});
		set(NOM, 40);
		chk_drv(6'h3F);
		chk("soft_start_go", 32'h1, {31'h0, drive_out.soft_start_go});
		// register access
		axi(1'b0, CTRL_OFS, 32'h0, rs, rd);
		chk("ctrl_reset", {31'h0, CTRL_OPEN_DET_RST}, {31'h0, rd[CTRL_OPEN_DET_BIT]});
		axi(1'b1, CTRL_OFS, 32'h0, rs, rd);
		chk("ctrl_wr_resp", {30'h0, RESP_OKAY}, {30'h0, rs});
		axi(1'b0, CTRL_OFS, 32'h0, rs, rd);
		chk("ctrl_rd", 32'h0, {31'h0, rd[CTRL_OPEN_DET_BIT]});
		s = NOM;
		s.string_below_reg = 4'h1;
		set(s, 5);
		chk("raise_gated", 32'h0, {31'h0, drive_out.raise_target});
		axi(1'b1, STATUS_OFS, 32'hFFFFFFFF, rs, rd);
		chk("status_wr_resp", {30'h0, RESP_OKAY}, {30'h0, rs});
		axi(1'b0, STATUS_OFS, 32'h0, rs, rd);
		chk("status_mode", 32'h3, {30'h0, rd[STAT_MODE_LSB+:2]});
		axi(1'b0, 8'h08, 32'h0, rs, rd);
		chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
		chk("unmapped_rd", 32'h0, rd);
		// mid-run reset restores outputs and the control default
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk_drv(6'h01);
		chk("soft_start_go", 32'h0, {31'h0, drive_out.soft_start_go});
		@(posedge sys_clk);
		rst_n <= 1'b1;
		set(NOM, 40);
		chk_drv(6'h3F);
		axi(1'b0, CTRL_OFS, 32'h0, rs, rd);
		chk("ctrl_rst_again", {31'h0, CTRL_OPEN_DET_RST}, {31'h0, rd[CTRL_OPEN_DET_BIT]});
		final_report();
	end
endmodule : tb_top
